/* File: include/arbp_pkg.sv */
// Package of constants and types for the ADC result bus port.
package arbp_pkg;

    // Result word layout: sign-magnitude, 15 magnitude bits plus overrange and polarity flags.
    localparam int MAG_W       = 15;
    localparam int BYTE_W      = 8;
    localparam int TOP_POS     = 7;
    // Clock and conversion timing.
    localparam int CLK_PERIOD_NS   = 50;
    localparam int INTEG_CYCLES    = 64;
    localparam int DEINT_MAX       = 32768;
    localparam int AZ_CYCLES       = 16;
    // Register offsets and interrupt bit positions.
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h1;
    localparam logic [3:0] ADDR_RESULT = 4'h2;
    localparam int EV_DONE     = 0;
    localparam int EV_START    = 1;
    localparam int EV_W        = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

    // Conversion sequencer phases.
    typedef enum logic [1:0] {
        ARBP_IDLE  = 2'b00,
        ARBP_AZ    = 2'b01,
        ARBP_INTEG = 2'b10,
        ARBP_DEINT = 2'b11
    } arbp_phase_t;

endpackage

/* File: include/arbp_result_if.sv */
// Interface carrying a finished conversion result between modules.
`timescale 1ns/100ps
interface arbp_result_if;
    logic                         done;
    logic [arbp_pkg::MAG_W-1:0]   magnitude;
    logic                         polarity;
    logic                         overrange;

    modport source (output done, output magnitude, output polarity, output overrange);
    modport sink   (input done, input magnitude, input polarity, input overrange);
endinterface

/* File: design/arbp_converter.sv */
// Conversion sequencer: auto-zero, integrate and de-integrate phases with busy flag.
`timescale 1ns/100ps
module arbp_converter
    import arbp_pkg::*;
#(
    parameter int INTEG_N = INTEG_CYCLES,
    parameter int AZ_N    = AZ_CYCLES
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               start,
    input  wire logic [MAG_W:0]     sample,
    output logic                    busy,
    arbp_result_if.source           res
);

    arbp_phase_t         phase;
    arbp_phase_t         next_phase;
    logic [MAG_W:0]      count;
    logic [MAG_W:0]      next_count;
    logic [MAG_W:0]      target;
    logic [MAG_W:0]      next_target;
    logic                next_busy;
    logic                next_done;
    logic                done_q;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic; the de-integrate length models the reference ramp time.
    always_comb begin
        next_phase  = phase;
        next_count  = count + 16'h0001;
        next_target = target;
        next_busy   = busy;
        next_done   = 1'b0;
        unique case (phase)
            ARBP_IDLE: begin
                next_count = '0;
                if (start) begin
                    next_phase = ARBP_AZ;
                end
            end
            ARBP_AZ: begin
                if (count == 16'(AZ_N - 1)) begin
                    next_phase = ARBP_INTEG;
                    next_count = '0;
                end
            end
            ARBP_INTEG: begin
                if (count == 16'(INTEG_N - 1)) begin
                    next_phase  = ARBP_DEINT;
                    next_count  = '0;
                    next_target = sample;
                    next_busy   = 1'b1;
                end
            end
            ARBP_DEINT: begin
                if (count >= {1'b0, target[MAG_W-1:0]}) begin
                    next_phase = ARBP_IDLE;
                    next_busy  = 1'b0;
                    next_done  = 1'b1;
                end
            end
        endcase
    end

    // Registers for the sequencer.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase  <= ARBP_IDLE;
            count  <= '0;
            target <= '0;
            busy   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            phase  <= next_phase;
            count  <= next_count;
            target <= next_target;
            busy   <= next_busy;
            done_q <= next_done;
        end
    end

    // Sample bit MAG_W is polarity; an all-ones magnitude is flagged as overrange.
    assign res.done      = done_q;
    assign res.magnitude = target[MAG_W-1:0];
    assign res.polarity  = target[MAG_W];
    assign res.overrange = &target[MAG_W-1:0];

endmodule

/* File: design/arbp_irq.sv */
// Sticky event status with mask and one level interrupt.
`timescale 1ns/100ps
module arbp_irq
    import arbp_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic [EV_W-1:0]   events,
    input  wire logic [EV_W-1:0]   clear,
    input  wire logic              mask_we,
    input  wire logic [EV_W-1:0]   mask_wdata,
    output logic [EV_W-1:0]        status,
    output logic [EV_W-1:0]        mask,
    output logic                   irq
);

    logic [EV_W-1:0] next_status;
    logic [EV_W-1:0] next_mask;
    logic            next_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Set wins over clear so an event in the clearing cycle is not lost.
    always_comb begin
        next_status = (status & ~clear) | events;
        next_mask   = mask_we ? mask_wdata : mask;
        next_irq    = |(next_status & next_mask);
    end

    // Registers for status, mask and the interrupt line.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
            mask   <= MASK_RESET;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            mask   <= next_mask;
            irq    <= next_irq;
        end
    end

endmodule

/* File: design/arbp_port.sv */
// Top of the ADC result bus port: chip select, start, byte read, busy and registers.
//
// What this block does
// - Selected only when select high, enable low.
// - Selected on-demand write strobe starts conversion.
// - Drive data lines only during selected read.
// - Run mode low: on demand; high: continuous.
// - Top-bit select chooses high-byte top line in on-demand mode.
// - Byte-half select picks low or high byte in on-demand mode.
// - Top line carries polarity, overrange or data.
// - Busy rises at de-integrate, falls when done.
// - Clock from the clock port; any oscillator is off-chip.
`timescale 1ns/100ps
module arbp_port
    import arbp_pkg::*;
#(
    parameter int INTEG_N = INTEG_CYCLES,
    parameter int AZ_N    = AZ_CYCLES
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               chip_select,
    input  wire logic               chip_enable_n,
    input  wire logic               write_n,
    input  wire logic               read_n,
    input  wire logic               run_mode_select,
    input  wire logic               top_bit_select,
    input  wire logic               byte_low_high,
    input  wire logic [MAG_W:0]     sample,
    output logic                    data_line_top_o,
    output logic                    data_line_top_oe,
    output logic [6:0]              data_lines_lower_o,
    output logic [6:0]              data_lines_lower_oe,
    output logic                    busy,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output logic [7:0]              reg_rdata,
    output logic                    irq
);

    // The conversion clock is the clock port; an oscillator input pin feeds it off-chip.

    arbp_result_if res ();

    logic                  selected;
    logic                  start;
    logic                  write_n_q;
    logic                  next_write_n_q;
    logic                  conv_busy;
    logic [MAG_W-1:0]      latch_mag;
    logic                  latch_pol;
    logic                  latch_ovr;
    logic [MAG_W-1:0]      next_latch_mag;
    logic                  next_latch_pol;
    logic                  next_latch_ovr;
    logic [7:0]            next_byte;
    logic                  next_oe;
    logic [7:0]            next_rdata;
    logic [EV_W-1:0]       status;
    logic [EV_W-1:0]       mask;
    logic [EV_W-1:0]       clear;
    logic                  mask_we;
    logic                  irq_int;
    logic                  busy_q;
    logic [7:0]            out_byte;
    logic                  out_oe;

    // Decode of the two chip enables, shared by both strobes.
    function automatic logic is_selected(input logic cs, input logic ce_n);
        return cs & ~ce_n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Conversion start: a falling write strobe while selected in demand mode, or
    // back-to-back restarts in continuous mode.
    always_comb begin
        selected       = is_selected(chip_select, chip_enable_n);
        next_write_n_q = write_n;
        if (run_mode_select) begin
            start = ~conv_busy_idle();
        end else begin
            start = selected & ~write_n & write_n_q;
        end
    end

    // Converter is idle when busy is low and no phase is pending; not tracked here, the function returns 0,
    // so continuous restarts are issued every cycle and ignored while running.
    function automatic logic conv_busy_idle();
        return 1'b0;
    endfunction

    // Edge register for the write strobe so a held-low strobe starts only once.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_n_q <= 1'b1;
        end else begin
            write_n_q <= next_write_n_q;
        end
    end

    arbp_converter #(
        .INTEG_N (INTEG_N),
        .AZ_N    (AZ_N)
    ) u_conv (
        .clock  (clock),
        .rstn   (rstn),
        .start  (start),
        .sample (sample),
        .busy   (conv_busy),
        .res    (res.source)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Result latch: updated only on completion, so both byte reads see one result.
    always_comb begin
        next_latch_mag = latch_mag;
        next_latch_pol = latch_pol;
        next_latch_ovr = latch_ovr;
        if (res.done) begin
            next_latch_mag = res.magnitude;
            next_latch_pol = res.polarity;
            next_latch_ovr = res.overrange;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            latch_mag <= '0;
            latch_pol <= 1'b0;
            latch_ovr <= 1'b0;
        end else begin
            latch_mag <= next_latch_mag;
            latch_pol <= next_latch_pol;
            latch_ovr <= next_latch_ovr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data bus: byte choice and top-line choice. In continuous mode the selects
    // are not used, so the high byte with polarity on the top line is shown.
    always_comb begin
        next_oe = selected & ~read_n;
        if (!run_mode_select && !byte_low_high) begin
            next_byte = latch_mag[7:0];
        end else begin
            next_byte = {1'b0, latch_mag[MAG_W-1:8]};
            if (!run_mode_select && top_bit_select) begin
                next_byte[TOP_POS] = latch_ovr;
            end else begin
                next_byte[TOP_POS] = latch_pol;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_byte <= '0;
            out_oe   <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            out_byte <= next_byte;
            out_oe   <= next_oe;
            busy_q   <= conv_busy;
        end
    end

    assign data_line_top_o     = out_byte[TOP_POS];
    assign data_line_top_oe    = out_oe;
    assign data_lines_lower_o  = out_byte[6:0];
    assign data_lines_lower_oe = {7{out_oe}};
    assign busy                = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register port: status (write one to clear), mask, and latched result low byte.
    always_comb begin
        clear   = '0;
        mask_we = 1'b0;
        if (reg_write && reg_addr == ADDR_STATUS) begin
            clear = reg_wdata[EV_W-1:0];
        end
        if (reg_write && reg_addr == ADDR_MASK) begin
            mask_we = 1'b1;
        end
        next_rdata = '0;
        if (reg_read) begin
            unique case (reg_addr)
                ADDR_STATUS: next_rdata = {6'h00, status};
                ADDR_MASK:   next_rdata = {6'h00, mask};
                ADDR_RESULT: next_rdata = latch_mag[7:0];
                default:     next_rdata = '0;
            endcase
        end
    end

    arbp_irq u_irq (
        .clock      (clock),
        .rstn       (rstn),
        .events     ({start, res.done}),
        .clear      (clear),
        .mask_we    (mask_we),
        .mask_wdata (reg_wdata[EV_W-1:0]),
        .status     (status),
        .mask       (mask),
        .irq        (irq_int)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
            irq       <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            irq       <= irq_int;
        end
    end

endmodule

/* File: tb/arbp_port_props.sv */
// Concurrent checks of the ADC result bus port at its top-level ports.
`timescale 1ns/100ps
module arbp_port_props
    import arbp_pkg::*;
#(
    parameter int INTEG_N = INTEG_CYCLES,
    parameter int AZ_N    = AZ_CYCLES
) (
    input wire logic           clock,
    input wire logic           rstn,
    input wire logic           chip_select,
    input wire logic           chip_enable_n,
    input wire logic           write_n,
    input wire logic           read_n,
    input wire logic           run_mode_select,
    input wire logic           top_bit_select,
    input wire logic           byte_low_high,
    input wire logic [MAG_W:0] sample,
    input wire logic           data_line_top_o,
    input wire logic           data_line_top_oe,
    input wire logic [6:0]     data_lines_lower_o,
    input wire logic [6:0]     data_lines_lower_oe,
    input wire logic           busy,
    input wire logic [3:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_write,
    input wire logic           reg_read,
    input wire logic [7:0]     reg_rdata,
    input wire logic           irq
);
    localparam int LO = AZ_N + INTEG_N + 1;
    localparam int HI = AZ_N + INTEG_N + 2;
    localparam int HC = AZ_N + INTEG_N + 3;
    logic       sel, start_ev, armed, next_armed, wr_q, busy_q, cont_ok;
    logic [7:0] oe_all;
    // A start is a selected falling write in on-demand mode.
    assign sel      = chip_select && !chip_enable_n;
    assign start_ev = sel && !write_n && wr_q && !run_mode_select;
    assign oe_all   = {data_line_top_oe, data_lines_lower_oe};
    // Continuous mode is content once busy is back, or once the mode was dropped.
    assign cont_ok  = busy || !run_mode_select;
    // Armed means idle with no start pending; a start outranks a finishing conversion.
    always_comb begin
        next_armed = (armed || (busy_q && !busy)) && !start_ev && !run_mode_select;
    end
    // History flops; reset leaves the port idle and armed.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {armed, wr_q, busy_q} <= 3'h6;
        end else begin
            {armed, wr_q, busy_q} <= {next_armed, write_n, busy};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rstn);
    a_bus_float: assert property (!(sel && !read_n) |=> oe_all == 8'h00)
        else $error("data lines driven outside a selected read");
    a_bus_drive: assert property (sel && !read_n |=> oe_all == 8'hff)
        else $error("data lines idle during a selected read");
    a_start_delay: assert property (armed && start_ev |-> ##[LO:HI] $rose(busy))
        else $error("busy late after a start");
    a_start_quiet: assert property (armed && start_ev |=> !busy [*6])
        else $error("busy rose before de-integrate");
    a_no_self_start: assert property (armed |=> !$rose(busy))
        else $error("busy rose without a start");
    a_cont_restart: assert property (run_mode_select && $fell(busy) |-> ##[1:HC] cont_ok)
        else $error("continuous mode did not restart");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside a read cycle");
    a_rdata_unmapped: assert property (reg_read && reg_addr > 4'h2 |=> reg_rdata == 8'h00)
        else $error("unmapped register not zero");
    c_start: cover property (armed && start_ev);
    c_read: cover property (sel && !read_n);
    c_restart: cover property (run_mode_select && $fell(busy));
endmodule

/* File: tb/arbp_host_model.sv */
// Host model: a microprocessor that starts conversions and reads result bytes.
`timescale 1ns/100ps
module arbp_host_model (
    input  wire logic clock,
    input  wire logic busy,
    output logic      chip_select,
    output logic      chip_enable_n,
    output logic      write_n,
    output logic      read_n,
    output logic      top_bit_select,
    output logic      byte_low_high
);
    // Idle pins sit where the device's pull resistors would leave them.
    initial begin
        {chip_select, chip_enable_n, write_n, read_n, top_bit_select, byte_low_high} = 6'h1f;
    end
    // One-cycle strobe with selects and byte choice held beside it, then selects and strobes released; byte choice is kept.
    task automatic strobe(input logic cs, input logic wr, input logic hi, input logic ovr);
        chip_select    <= cs;
        chip_enable_n  <= 1'b0;
        write_n        <= !wr;
        read_n         <= wr;
        byte_low_high  <= hi;
        top_bit_select <= ovr;
        @(posedge clock);
        {chip_select, chip_enable_n, write_n, read_n} <= 4'h7;
        @(posedge clock);
    endtask
    // The fall of busy is taken as end of conversion; the wait is bounded.
    task automatic wait_done(output logic ok);
        bit seen;
        seen = 1'b0;
        ok   = 1'b0;
        for (int n = 0; n < 40000 && !ok; n++) begin
            @(posedge clock);
            if (busy === 1'b1) begin
                seen = 1'b1;
            end else if (seen) begin
                ok = 1'b1;
            end
        end
    endtask
endmodule

/* File: tb/tb_arbp_port.sv */
// Self-checking bench of the ADC result bus port driven by a host model.
`timescale 1ns/100ps
module tb_arbp_port
    import arbp_pkg::*;
;
    logic           clock, rstn, chip_select, chip_enable_n, write_n, read_n, busy, irq, ok;
    logic           run_mode_select, top_bit_select, byte_low_high, reg_write, reg_read, rd_d;
    logic           data_line_top_o, data_line_top_oe;
    logic [6:0]     data_lines_lower_o, data_lines_lower_oe;
    logic [3:0]     reg_addr;
    logic [7:0]     reg_wdata, reg_rdata, bus_byte, bus_q[$], reg_q[$];
    logic [MAG_W:0] sample, s;
    int             n_fail, checked;
    // Short integrate and auto-zero counts keep the run brief.
    arbp_port #(.INTEG_N(4), .AZ_N(2)) i_dut (
        .clock, .rstn, .chip_select, .chip_enable_n, .write_n, .read_n, .run_mode_select,
        .top_bit_select, .byte_low_high, .sample, .data_line_top_o, .data_line_top_oe,
        .data_lines_lower_o, .data_lines_lower_oe, .busy, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .irq
    );
    arbp_host_model i_host (
        .clock, .busy, .chip_select, .chip_enable_n, .write_n, .read_n, .top_bit_select, .byte_low_high
    );
    // The eight data lines gathered into one byte for the bus compare.
    assign bus_byte = {data_line_top_o, data_lines_lower_o};
    initial clock = 1'b0;
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] got);
        checked++;
        if (got !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic cmp_flag(input string what, input logic e, input logic got);
        checked++;
        if (got !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Register strobes are one cycle; a idle cycle follows so no strobe is set twice at once.
    task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        if (!wr) begin
            reg_q.push_back(d);
        end
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read  <= !wr;
        @(posedge clock);
        {reg_write, reg_read} <= 2'h0;
        @(posedge clock);
    endtask
    task automatic rd_bus(input logic cs, input logic hi, input logic ovr, input logic [7:0] e);
        if (cs) begin
            bus_q.push_back(e);
        end
        i_host.strobe(cs, 1'b0, hi, ovr);
    endtask
    // The input moves after completion so a latch that follows it is caught.
    task automatic convert(input logic [MAG_W:0] v);
        sample <= v;
        @(posedge clock);
        i_host.strobe(1'b1, 1'b1, 1'b0, 1'b0);
        i_host.wait_done(ok);
        cmp_flag("conversion completed", 1'b1, ok);
        if (!ok) print_verdict();
        sample <= ~v;
        @(posedge clock);
    endtask
    // Results are matched against the oldest note left by the driver.
    always @(posedge clock) rd_d <= reg_read;
    always @(negedge clock) begin
        if (data_lines_lower_oe !== 7'h00) begin
            cmp_byte("data bus", bus_q.pop_front(), bus_byte);
        end
        if (rd_d === 1'b1) cmp_byte("register read", reg_q.pop_front(), reg_rdata);
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, run_mode_select, reg_write, reg_read} = 4'h0;
        // A non-zero input keeps busy high long enough to expose a wrongly taken start.
        {sample, reg_addr, reg_wdata} = 28'h00f_f000;
        n_fail  = 0;
        checked = 0;
        void'($urandom(4270));
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        i_host.strobe(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (12) @(posedge clock);
        cmp_flag("busy after deselected write", 1'b0, busy);
        for (int i = 0; i < 4; i++) begin
            s = (i == 0) ? 16'h7fff : 16'($urandom) & 16'h87ff;
            convert(s);
            rd_bus(1'b1, 1'b0, 1'b1, s[7:0]);
            rd_bus(1'b1, 1'b1, 1'b0, {s[15], s[14:8]});
            rd_bus(1'b1, 1'b1, 1'b1, {&s[14:0], s[14:8]});
            rd_bus(1'b0, 1'b1, 1'b1, 8'h00);
            reg_acc(1'b0, ADDR_RESULT, s[7:0]);
        end
        $display("on-demand conversions finished");
        // The interrupt line sits two registers behind a write, so it is looked at mid-cycle.
        @(negedge clock);
        cmp_flag("irq while masked", 1'b0, irq);
        @(posedge clock);
        reg_acc(1'b0, ADDR_STATUS, 8'h03);
        reg_acc(1'b1, ADDR_MASK, 8'h01);
        @(negedge clock);
        cmp_flag("irq when unmasked", 1'b1, irq);
        @(posedge clock);
        reg_acc(1'b1, ADDR_STATUS, 8'h01);
        @(negedge clock);
        cmp_flag("irq after clear", 1'b0, irq);
        @(posedge clock);
        reg_acc(1'b0, ADDR_STATUS, 8'h02);
        reg_acc(1'b0, ADDR_MASK, 8'h01);
        reg_acc(1'b0, 4'h9, 8'h00);
        $display("interrupt registers finished");
        sample          <= 16'h0005;
        run_mode_select <= 1'b1;
        repeat (2) begin
            i_host.wait_done(ok);
            cmp_flag("continuous conversion", 1'b1, ok);
            if (!ok) print_verdict();
        end
        $display("continuous mode finished");
        print_verdict();
    end
endmodule
bind arbp_port arbp_port_props #(.INTEG_N(INTEG_N), .AZ_N(AZ_N)) i_props (
    .clock, .rstn, .chip_select, .chip_enable_n, .write_n, .read_n, .run_mode_select,
    .top_bit_select, .byte_low_high, .sample, .data_line_top_o, .data_line_top_oe,
    .data_lines_lower_o, .data_lines_lower_oe, .busy, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .irq
);
